// ==== hdl/stap_cfg.svh ====
`ifndef STAP_CFG_SVH
`define STAP_CFG_SVH
// Instruction codes
`define STAP_IR_W        3
`define STAP_OP_EXTEST   3'h0
`define STAP_OP_IDCODE   3'h1
`define STAP_OP_SAMPZ    3'h2
`define STAP_OP_SAMPLE   3'h4
`define STAP_OP_BYPASS   3'h7
// Capture pattern for the instruction register
`define STAP_IR_CAPTURE  3'h1
// Chain lengths
`define STAP_BSR_LEN     75
`define STAP_ID_LEN      32
// Identification fields; all values arbitrary
`define STAP_ID_VALUE    32'h0123_4565
`endif

// ==== hdl/stap_pkg.sv ====
package stap_pkg;
  // Test-port controller states
  typedef enum logic [3:0] {
    TEST_RESET = 4'b0000, RUN_IDLE   = 4'b0001, SEL_DR     = 4'b0010,
    CAP_DR     = 4'b0011, SHIFT_DR   = 4'b0100, EXIT1_DR   = 4'b0101,
    PAUSE_DR   = 4'b0110, EXIT2_DR   = 4'b0111, UPD_DR     = 4'b1000,
    SEL_IR     = 4'b1001, CAP_IR     = 4'b1010, SHIFT_IR   = 4'b1011,
    EXIT1_IR   = 4'b1100, PAUSE_IR   = 4'b1101, EXIT2_IR   = 4'b1110,
    UPD_IR     = 4'b1111
  } stap_state_t;
endpackage : stap_pkg

// ==== hdl/stap_tap.sv ====
`timescale 1ns/1ps
`include "stap_cfg.svh"
// Functional notes
// - Code 000 captures ring, selects boundary chain, floats memory outputs.
// - Code 001 loads identification value, selects it, memory undisturbed.
// - Code 010 captures ring, selects boundary chain, floats memory outputs.
// - Code 100 captures ring, selects boundary chain; shifted data never reaches pins.
// - Code 111 selects one-bit bypass register, memory undisturbed.
// - Boundary chain has 75 cells; cell 1 mode pin, 74 A1, 75 A0.
// - Serial out changes on test clock falling edge, valid within 20 ns.
// - Instruction register is three bits, applied at update.
// - Reset and test-logic-reset load the identification instruction.
// - Cell 75 next to serial out, shifts out first; cell 1 next to serial in.
module stap_tap (
  // System clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  // Test port, on its own clock
  input  wire logic                     tck,
  input  wire logic                     tms,
  input  wire logic                     tdi,
  output logic                          tdo,
  output logic                          tdoEn,
  // Ring sampled into the boundary chain, cell 1 at bit 0
  input  wire logic [`STAP_BSR_LEN-1:0] ringIn,
  // Memory output float request, in the system domain
  output logic                          memHighZ
);

  ////////////////////////////////////////////////////////////////////////////
  // Test clock domain
  // Everything up to the float flop runs on the test clock alone.
  // The test clock may stop between frames, so no result may wait for
  // a later edge to become visible.
  // The ring is read straight into the chain at capture; the controller
  // owns setup and hold around that edge, so no synchroniser sits there
  // (a per-bit synchroniser would tear the snapshot apart anyway).
  stap_pkg::stap_state_t     state_q;
  stap_pkg::stap_state_t     state_d;
  logic [`STAP_IR_W-1:0]     irShift_q;
  logic [`STAP_IR_W-1:0]     ir_q;
  logic [`STAP_BSR_LEN-1:0]  bsr_q;
  logic [`STAP_ID_LEN-1:0]   id_q;
  logic                      byp_q;
  logic                      float_q;

  // Next state, standard sequencing on mode select
  // Five high mode-select samples reach test-logic reset from any state,
  // so a controller that lost track can always resynchronise.
  // Unused encodings cannot occur; the default still steers to reset.
  always_comb begin
    case (state_q)
      stap_pkg::TEST_RESET: state_d = tms ? stap_pkg::TEST_RESET : stap_pkg::RUN_IDLE;
      stap_pkg::RUN_IDLE:   state_d = tms ? stap_pkg::SEL_DR     : stap_pkg::RUN_IDLE;
      stap_pkg::SEL_DR:     state_d = tms ? stap_pkg::SEL_IR     : stap_pkg::CAP_DR;
      stap_pkg::CAP_DR:     state_d = tms ? stap_pkg::EXIT1_DR   : stap_pkg::SHIFT_DR;
      stap_pkg::SHIFT_DR:   state_d = tms ? stap_pkg::EXIT1_DR   : stap_pkg::SHIFT_DR;
      stap_pkg::EXIT1_DR:   state_d = tms ? stap_pkg::UPD_DR     : stap_pkg::PAUSE_DR;
      stap_pkg::PAUSE_DR:   state_d = tms ? stap_pkg::EXIT2_DR   : stap_pkg::PAUSE_DR;
      stap_pkg::EXIT2_DR:   state_d = tms ? stap_pkg::UPD_DR     : stap_pkg::SHIFT_DR;
      stap_pkg::UPD_DR:     state_d = tms ? stap_pkg::SEL_DR     : stap_pkg::RUN_IDLE;
      stap_pkg::SEL_IR:     state_d = tms ? stap_pkg::TEST_RESET : stap_pkg::CAP_IR;
      stap_pkg::CAP_IR:     state_d = tms ? stap_pkg::EXIT1_IR   : stap_pkg::SHIFT_IR;
      stap_pkg::SHIFT_IR:   state_d = tms ? stap_pkg::EXIT1_IR   : stap_pkg::SHIFT_IR;
      stap_pkg::EXIT1_IR:   state_d = tms ? stap_pkg::UPD_IR     : stap_pkg::PAUSE_IR;
      stap_pkg::PAUSE_IR:   state_d = tms ? stap_pkg::EXIT2_IR   : stap_pkg::PAUSE_IR;
      stap_pkg::EXIT2_IR:   state_d = tms ? stap_pkg::UPD_IR     : stap_pkg::SHIFT_IR;
      stap_pkg::UPD_IR:     state_d = tms ? stap_pkg::SEL_DR     : stap_pkg::RUN_IDLE;
      default:              state_d = stap_pkg::TEST_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode helpers

  // Codes that place the boundary chain between serial in and serial out
  function automatic logic usesBsr(input logic [`STAP_IR_W-1:0] code);
    usesBsr = (code == `STAP_OP_EXTEST) || (code == `STAP_OP_SAMPZ) ||
              (code == `STAP_OP_SAMPLE);
  endfunction : usesBsr

  // Codes that float the memory outputs for as long as they are current
  function automatic logic floatsMem(input logic [`STAP_IR_W-1:0] code);
    floatsMem = (code == `STAP_OP_EXTEST) || (code == `STAP_OP_SAMPZ);
  endfunction : floatsMem

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the current instruction and controller state
  wire selBsr    = usesBsr(ir_q);
  wire selId     = (ir_q == `STAP_OP_IDCODE);
  // Reserved codes fall through to bypass as a safe path
  wire selByp    = !selBsr && !selId;
  wire inShiftDr = (state_q == stap_pkg::SHIFT_DR);
  wire inShiftIr = (state_q == stap_pkg::SHIFT_IR);
  wire inCapDr   = (state_q == stap_pkg::CAP_DR);
  wire inCapIr   = (state_q == stap_pkg::CAP_IR);
  wire inUpdIr   = (state_q == stap_pkg::UPD_IR);
  wire inTlr     = (state_q == stap_pkg::TEST_RESET);

  // Instruction current after this test clock edge; the float flop follows
  // it on the same edge, since the test clock may stop right after update
  wire [`STAP_IR_W-1:0] irNext = inTlr   ? `STAP_OP_IDCODE :
                                 inUpdIr ? irShift_q : ir_q;
  wire floatNext = (state_d != stap_pkg::TEST_RESET) && floatsMem(irNext);

  // Data register at serial out: cell 75, identification bit 0 or bypass
  wire drOut     = selBsr ? bsr_q[`STAP_BSR_LEN-1] :
                   selId  ? id_q[0] : byp_q;
  wire serialOut = inShiftIr ? irShift_q[0] : drOut;

  // Controller state
  // Reset parks the controller in test-logic reset, the same place that
  // five high mode-select samples lead to.
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= stap_pkg::TEST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Instruction shift and update stages
  // The shift stage moves freely; the current instruction changes only
  // at update or in test-logic reset, so a half-shifted code never steers
  // the chains or the memory outputs.
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      irShift_q <= `STAP_OP_IDCODE;
      ir_q      <= `STAP_OP_IDCODE;
    end else if (state_q == stap_pkg::TEST_RESET) begin
      ir_q      <= `STAP_OP_IDCODE;
    end else if (inCapIr) begin
      irShift_q <= `STAP_IR_CAPTURE;
    end else if (inShiftIr) begin
      irShift_q <= {tdi, irShift_q[`STAP_IR_W-1:1]};
    end else if (state_q == stap_pkg::UPD_IR) begin
      ir_q      <= irShift_q;
    end
  end

  // Boundary chain: cell 1 at bit 0 beside serial in, cell 75 at the top
  // shifted out first; no update stage so shifted data never reaches pins
  // Capture takes the ring as it stands at that edge; a ring bit moving
  // there may land either way, which is the controller's concern.
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      bsr_q <= '0;
    end else if (selBsr && inCapDr) begin
      bsr_q <= ringIn;
    end else if (selBsr && inShiftDr) begin
      bsr_q <= {bsr_q[`STAP_BSR_LEN-2:0], tdi};
    end
  end

  // Identification register: fixed value at capture, LSB first out
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      id_q <= '0;
    end else if (selId && inCapDr) begin
      id_q <= `STAP_ID_VALUE;
    end else if (selId && inShiftDr) begin
      id_q <= {tdi, id_q[`STAP_ID_LEN-1:1]};
    end
  end

  // Bypass register: cleared at capture, one stage of delay while shifting
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      byp_q <= 1'b0;
    end else if (selByp && inCapDr) begin
      byp_q <= 1'b0;
    end else if (selByp && inShiftDr) begin
      byp_q <= tdi;
    end
  end

  // Serial out on falling edge, driven only while shifting
  // Moving on the falling edge gives the far end half a period of setup
  // before it samples on the next rising edge; the enable follows the
  // shift states so the pin floats outside them.
  always_ff @(negedge tck or negedge rst_b) begin
    if (!rst_b) begin
      tdo   <= 1'b0;
      tdoEn <= 1'b0;
    end else begin
      tdo   <= serialOut;
      tdoEn <= inShiftDr || inShiftIr;
    end
  end

  // Float request level, held while floating instruction is current;
  // set on the very edge that updates the instruction, dropped as soon
  // as the controller heads into test-logic reset
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      float_q <= 1'b0;
    end else begin
      float_q <= floatNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain: two-stage level synchroniser
  // The float request is a slow level, so two flops suffice; only the
  // second stage feeds the output, the first may still be settling.
  // The memory outputs follow two or three system clocks after update.
  logic floatMeta_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      floatMeta_q <= 1'b0;
      memHighZ    <= 1'b0;
    end else begin
      floatMeta_q <= float_q;
      memHighZ    <= floatMeta_q;
    end
  end

endmodule : stap_tap

// ==== test/stap_tap_chk.sv ====
`timescale 1ns/1ps
`include "stap_cfg.svh"
module stap_tap_chk (
  // Watched ports
  input wire logic clk_sys, rst_b, tck, tms, tdi, tdo, tdoEn, memHighZ,
  input wire logic [`STAP_BSR_LEN-1:0] ringIn
);
  // Quiet outputs while reset is held
  a_reset_quiet: assert property (@(posedge clk_sys)
    !rst_b |-> !memHighZ && !tdoEn) else $error("output active in reset");
  // Serial out moves only while test clock is low
  a_tdo_fall: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $changed(tdo) |-> !tck) else $error("tdo moved with tck high");
  a_en_fall: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $changed(tdoEn) |-> !tck) else $error("tdoEn moved with tck high");
  // Shift window follows mode select
  a_shift_hold: assert property (@(posedge tck) disable iff (!rst_b)
    tdoEn |=> tdoEn == !$past(tms)) else $error("shift window wrong");
  a_shift_entry: assert property (@(posedge tck) disable iff (!rst_b)
    $rose(tdoEn) |-> !$past(tms)) else $error("shift entered on high tms");
  a_tlr_quiet: assert property (@(posedge tck) disable iff (!rst_b)
    tms [*2] |-> !tdoEn) else $error("driving after two high tms");
  // Float drops after test-logic reset, holds during shifts
  a_tlr_float: assert property (@(posedge tck) disable iff (!rst_b)
    tms [*5] |-> ##3 !memHighZ) else $error("float kept after reset walk");
  a_hiz_steady: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tdoEn && $past(tdoEn) |-> $stable(memHighZ)) else $error("float moved in shift");
  // Main scenarios
  c_shift: cover property (@(posedge tck) $rose(tdoEn));
  c_float: cover property (@(posedge clk_sys) $rose(memHighZ));
  c_unfloat: cover property (@(posedge clk_sys) $fell(memHighZ));
endmodule : stap_tap_chk
bind stap_tap stap_tap_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .tck(tck), .tms(tms),
  .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .memHighZ(memHighZ), .ringIn(ringIn));

// ==== test/stap_ctl_model.sv ====
`timescale 1ns/1ps
module stap_ctl_model (
  // Test port pins
  output logic tck, tms, tdi,
  input wire logic tdo
);
  initial begin
    tck = 0;
    tms = 1;
    tdi = 0;
  end
  // One 125 ns test clock, resting low between frames
  task automatic step(input logic m, d, output logic o);
    #1 tms = m;
    tdi = d;
    #61.5 tck = 1;
    o = tdo;
    #62.5 tck = 0;
  endtask : step
  // Idle to shift, n bits, then update and spare clocks
  task automatic scan(input logic ir, input int n, input logic [74:0] din,
                      output logic [74:0] dout);
    logic o;
    dout = '0;
    step(1, 0, o);
    if (ir) step(1, 0, o);
    repeat (2) step(0, 0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1, 0, o);
    repeat (3) step(0, 0, o);
  endtask : scan
  // Test-logic reset, then idle
  task automatic tlr();
    logic o;
    repeat (5) step(1, 0, o);
    repeat (3) step(0, 0, o);
  endtask : tlr
endmodule : stap_ctl_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`include "stap_cfg.svh"
module testbench;
  logic clk_sys = 0, rst_b = 0, tdo, tdoEn, memHighZ;
  wire tck, tms, tdi;
  logic [74:0] ring = 75'h5a3_c3f0_9e17_b2d4_6c81, pat = 75'h2b6_d193_4ea5_07cf_8a3e, got;
  int error_cnt = 0, compares = 0;
  always #10 clk_sys = ~clk_sys;
  stap_tap u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoEn(tdoEn), .ringIn(ring), .memHighZ(memHighZ));
  stap_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic check(input string nm, input logic [74:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // Expected chain output per instruction
  function automatic logic [74:0] expDr(input logic [2:0] c);
    for (int i = 0; i < 75; i++)
      expDr[i] = c == 3'h1 ? (i < 32 ? `STAP_ID_VALUE >> i : pat[i - 32])
               : c inside {3'h0, 3'h2, 3'h4} ? ring[74 - i] : (i ? pat[i - 1] : 1'b0);
  endfunction : expDr
  task automatic t_codes();
    logic [2:0] codes[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7}; // Reserved codes skipped
    foreach (codes[k]) begin
      u_ctl.scan(1, 3, {72'h0, codes[k]}, got);
      check("ir capture", 75'h1, got);
      repeat (4) @(posedge clk_sys);
      #1 check("float", codes[k] inside {3'h0, 3'h2}, memHighZ);
      u_ctl.scan(0, 75, pat, got);
      check("chain", expDr(codes[k]), got);
      check("float held", codes[k] inside {3'h0, 3'h2}, memHighZ);
    end
    $display("codes test done");
  endtask : t_codes
  task automatic t_tlr();
    u_ctl.scan(1, 3, 75'h2, got);
    repeat (4) @(posedge clk_sys);
    #1 check("float on", 1'b1, memHighZ);
    u_ctl.tlr();
    repeat (4) @(posedge clk_sys);
    #1 check("float off", 1'b0, memHighZ);
    u_ctl.scan(0, 75, pat, got);
    check("id again", expDr(3'h1), got);
    $display("reset walk done");
  endtask : t_tlr
  task automatic t_reset();
    u_ctl.scan(1, 3, 75'h0, got);
    repeat (4) @(posedge clk_sys);
    #1 check("float before reset", 1'b1, memHighZ);
    #1 rst_b = 0;
    #1 check("float in reset", 1'b0, memHighZ);
    repeat (10) @(posedge clk_sys);
    #2 rst_b = 1;
    u_ctl.tlr();
    check("float after reset", 1'b0, memHighZ);
    u_ctl.scan(0, 75, pat, got);
    check("id after reset", expDr(3'h1), got);
    $display("mid-run reset done");
  endtask : t_reset
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clk_sys);
    #2 rst_b = 1;
    u_ctl.tlr();
    check("float at start", 1'b0, memHighZ);
    t_codes();
    t_tlr();
    t_reset();
    give_verdict();
  end
  // Watchdog well past the scan traffic
  initial begin
    #1_000_000;
    error_cnt++;
    give_verdict();
  end
endmodule : testbench
